// *** spc_regs.sv ***
// Configuration register group of a 24-port switch: masks, VLANs, strap config, duplex.
// Assumes a register port fed by the UART command decoder and PHY management inputs.
//
// Overview of operation
// - Back-pressure mask bit 1 disables port back-pressure
// - Isolation bit 1 stops port receive and transmit
// - 24 four-bit VLAN membership registers, any combination
// - VLAN membership resets to first VLAN only
// - Four dump-port IDs, only values 0 to 23
// - Bits 3:0 select read latch delay level
// - Bit 4 selects one or four memory rows
// - Bits 6:5 give buffer memory size
// - Bit 7 selects 1518 or 1530 long threshold
// - Bit 8 floods unknown destinations or dumps them
// - Bit 9 selects internal or external lookup table
// - Bit 10 shifts PHY IDs from 1 to 4
// - Bit 11 drops or retransmits after excessive collisions
// - Bit 12 stops automatic PHY status updates
// - Bit 13 picks receive clock sampling edge
// - Bit 14 picks software or hardware error reset
// - Bit 15 holds switch until CPU ready
// - Only commands with matching device ID answered
// - Bit 18 picks lookup clock latch edge
// - Config reset value loaded from strap pins
// - Twelve pairing bits join even and odd ports
// - Duplex status writable only when bit 12 set
// - Speed and link status follow same rule
`timescale 1ns/1ps

module spc_regs
    import spc_pkg::*;
(
    input wire logic clk_in, // 100 MHz clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic reg_wr_in, // Register write strobe
    input wire logic reg_rd_in, // Register read strobe
    input wire logic [1:0] reg_dev_id_in, // Command device ID field
    input wire logic [5:0] reg_num_in, // Register number
    input wire logic [4:0] reg_idx_in, // Port or VLAN index
    input wire logic [23:0] reg_wdata_in, // Write data
    output logic reg_ack_out, // Answer pulse
    output logic [23:0] reg_rdata_out, // Read data
    input wire logic [18:0] strap_cfg_in, // Config strap levels
    input wire logic [11:0] duplex_pair_strap_value_in, // Pairing strap levels
    input wire logic [23:0] phy_speed_in, // Speed from PHY management
    input wire logic [23:0] phy_link_in, // Link from PHY management
    input wire logic [11:0] phy_duplex_in, // Duplex from PHY management
    input wire logic sys_ready_in, // System-ready bit from CPU
    input wire logic sys_error_in, // System error event pulse
    output logic [23:0] bp_enable_out, // Back-pressure allowed per port
    output logic [23:0] port_enable_out, // Port may pass frames
    output logic [95:0] vlan_member_out, // Four bits per port
    output logic [19:0] vlan_dump_port_out, // Five bits per VLAN
    output spc_cfg_t cfg_out, // Decoded configuration
    output logic [11:0] duplex_pair_enable_out, // Pairing per even port
    output logic [11:0] duplex_mode_status_out, // Duplex status
    output logic [23:0] speed_status_out, // Speed status
    output logic [23:0] link_status_out, // Link status
    output logic switch_run_out, // Switch may operate
    output logic sw_reset_req_out, // Internal reset pulse
    output logic hw_reset_req_out // Watchdog stop pulse
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] lat_level(input logic [3:0] code);
        lat_level = (code == 4'h0) ? 4'h0 : {1'b0, code[3:1]} + 4'h1;
    endfunction : lat_level

    function automatic logic [19:0] mem_words(input logic [1:0] sz);
        mem_words = SPC_MEM_MIN << sz;
    endfunction : mem_words

    spc_state_t s_reg;
    spc_state_t s_next;
    logic id_ok;
    logic wr_ok;
    logic auto_pm;
    logic [23:0] wd;

    assign id_ok = reg_dev_id_in == s_reg.cfg[SPC_CFG_DEVID +: 2];
    assign wr_ok = reg_wr_in && id_ok && s_reg.strap_done;
    assign auto_pm = !s_reg.cfg[SPC_CFG_NOPM];
    assign wd = reg_wdata_in;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.sw_rst = 1'b0;
        s_next.hw_rst = 1'b0;
        if (!s_reg.strap_done) begin
            s_next.cfg = strap_cfg_in;
            s_next.pair = duplex_pair_strap_value_in;
            s_next.strap_done = 1'b1;
        end
        if (auto_pm) begin
            s_next.duplex_mode_status = phy_duplex_in;
            s_next.speed = phy_speed_in;
            s_next.link = phy_link_in;
        end
        if (sys_error_in && s_reg.strap_done) begin
            s_next.sw_rst = !s_reg.cfg[SPC_CFG_HWRST];
            s_next.hw_rst = s_reg.cfg[SPC_CFG_HWRST];
        end
        if (wr_ok) begin
            case (reg_num_in)
                SPC_REG_BP: s_next.bp_mask = wd;
                SPC_REG_ISO: s_next.iso_mask = wd;
                SPC_REG_VLAN: begin
                    if (reg_idx_in <= SPC_PORT_MAX) begin
                        s_next.vlan[reg_idx_in] = wd[3:0];
                    end
                end
                SPC_REG_DUMP: begin
                    if (reg_idx_in[4:2] == 3'h0 && wd[4:0] <= SPC_PORT_MAX) begin
                        s_next.dump[reg_idx_in[1:0]] = wd[4:0];
                    end
                end
                SPC_REG_CFG: s_next.cfg = wd[18:0];
                SPC_REG_FDP: s_next.pair = wd[11:0];
                SPC_REG_DUPLEX_MODE_STATUS: begin
                    if (!auto_pm) begin
                        s_next.duplex_mode_status = wd[11:0];
                    end
                end
                SPC_REG_SPEED: begin
                    if (!auto_pm) begin
                        s_next.speed = wd;
                    end
                end
                SPC_REG_LINK: begin
                    if (!auto_pm) begin
                        s_next.link = wd;
                    end
                end
                default: ;
            endcase
        end
        if ((reg_wr_in || reg_rd_in) && id_ok && s_reg.strap_done) begin
            s_next.ack = 1'b1;
            s_next.rdata = 24'h000000;
            if (reg_rd_in) begin
                case (reg_num_in)
                    SPC_REG_BP: s_next.rdata = s_reg.bp_mask;
                    SPC_REG_ISO: s_next.rdata = s_reg.iso_mask;
                    SPC_REG_VLAN: begin
                        if (reg_idx_in <= SPC_PORT_MAX) begin
                            s_next.rdata = {20'h00000, s_reg.vlan[reg_idx_in]};
                        end
                    end
                    SPC_REG_DUMP: begin
                        if (reg_idx_in[4:2] == 3'h0) begin
                            s_next.rdata = {19'h00000, s_reg.dump[reg_idx_in[1:0]]};
                        end
                    end
                    SPC_REG_CFG: s_next.rdata = {5'h00, s_reg.cfg};
                    SPC_REG_FDP: s_next.rdata = {12'h000, s_reg.pair};
                    SPC_REG_DUPLEX_MODE_STATUS: s_next.rdata = {12'h000, s_reg.duplex_mode_status};
                    SPC_REG_SPEED: s_next.rdata = s_reg.speed;
                    SPC_REG_LINK: s_next.rdata = s_reg.link;
                    default: s_next.rdata = 24'h000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_reg.bp_mask <= SPC_MASK_RST;
            s_reg.iso_mask <= SPC_MASK_RST;
            s_reg.vlan <= {SPC_PORT_ISOLATE_MASK{SPC_VLAN_RST}};
            s_reg.dump <= {SPC_NVLAN{SPC_DUMP_RST}};
            s_reg.cfg <= SPC_CFG_RST;
            s_reg.pair <= SPC_PAIR_RST;
            s_reg.duplex_mode_status <= 12'h000;
            s_reg.speed <= SPC_MASK_RST;
            s_reg.link <= SPC_MASK_RST;
            s_reg.strap_done <= 1'b0;
            s_reg.ack <= 1'b0;
            s_reg.rdata <= 24'h000000;
            s_reg.sw_rst <= 1'b0;
            s_reg.hw_rst <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_ack_out = s_reg.ack;
    assign reg_rdata_out = s_reg.rdata;
    assign bp_enable_out = ~s_reg.bp_mask;
    assign port_enable_out = ~s_reg.iso_mask;
    assign vlan_member_out = s_reg.vlan;
    assign vlan_dump_port_out = s_reg.dump;
    assign duplex_pair_enable_out = s_reg.pair;
    assign duplex_mode_status_out = s_reg.duplex_mode_status;
    assign speed_status_out = s_reg.speed;
    assign link_status_out = s_reg.link;
    assign sw_reset_req_out = s_reg.sw_rst;
    assign hw_reset_req_out = s_reg.hw_rst;
    assign switch_run_out = s_reg.strap_done
        && (!s_reg.cfg[SPC_CFG_WAIT] || sys_ready_in);

    always_comb begin
        cfg_out.lat_level = lat_level(s_reg.cfg[SPC_CFG_LAT +: 4]);
        cfg_out.row_mode = s_reg.cfg[SPC_CFG_ORG];
        cfg_out.mem_words = mem_words(s_reg.cfg[SPC_CFG_SIZE +: 2]);
        cfg_out.long_len = s_reg.cfg[SPC_CFG_LONG] ? SPC_LONG_EXT : SPC_LONG_STD;
        cfg_out.flood_unknown = s_reg.cfg[SPC_CFG_FLOOD];
        cfg_out.ext_lookup = s_reg.cfg[SPC_CFG_EXTLU];
        cfg_out.phy_id_base = s_reg.cfg[SPC_CFG_PHYID] ? SPC_PHYID_HI : SPC_PHYID_LO;
        cfg_out.drop_excess_col = s_reg.cfg[SPC_CFG_DROP];
        cfg_out.auto_phy_mgmt = auto_pm;
        cfg_out.rx_fall_edge = s_reg.cfg[SPC_CFG_RXFALL];
        cfg_out.lookup_fall_edge = s_reg.cfg[SPC_CFG_LUFALL];
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    chk_id_ack: assert property (
        (reg_wr_in || reg_rd_in) && s_reg.strap_done |=> reg_ack_out == $past(id_ok))
        else $error("ack does not follow device ID match");
    chk_bp_write: assert property (
        wr_ok && reg_num_in == SPC_REG_BP |=> bp_enable_out == ~$past(reg_wdata_in))
        else $error("back-pressure enable not inverse of written mask");
    chk_iso_write: assert property (
        wr_ok && reg_num_in == SPC_REG_ISO |=> port_enable_out == ~$past(reg_wdata_in))
        else $error("port enable not inverse of isolation mask");
    chk_vlan_reset: assert property (
        $rose(s_reg.strap_done) |-> vlan_member_out == {SPC_PORT_ISOLATE_MASK{SPC_VLAN_RST}})
        else $error("VLAN membership not first VLAN after reset");
    chk_dump_range: assert property (
        vlan_dump_port_out[4:0] <= SPC_PORT_MAX && vlan_dump_port_out[9:5] <= SPC_PORT_MAX
        && vlan_dump_port_out[14:10] <= SPC_PORT_MAX
        && vlan_dump_port_out[19:15] <= SPC_PORT_MAX)
        else $error("dump port holds invalid ID");
    chk_strap_load: assert property (
        !s_reg.strap_done ##1 s_reg.strap_done |-> s_reg.cfg == $past(strap_cfg_in))
        else $error("config not loaded from straps");
    chk_status_hold: assert property (
        auto_pm && wr_ok && reg_num_in == SPC_REG_LINK && !cfg_out.auto_phy_mgmt == 1'b0
        |=> link_status_out == $past(phy_link_in))
        else $error("link status overwritten in read-only mode");
    chk_manual_hold: assert property (
        !auto_pm && !wr_ok && $stable(s_reg.cfg) |=> $stable(duplex_mode_status_out))
        else $error("duplex status changed without CPU write");
    chk_long_len: assert property (
        cfg_out.long_len == (s_reg.cfg[SPC_CFG_LONG] ? 11'h5FA : 11'h5EE))
        else $error("long frame threshold wrong");
    chk_run_hold: assert property (
        s_reg.cfg[SPC_CFG_WAIT] && !sys_ready_in |-> !switch_run_out)
        else $error("switch runs before system ready");
    chk_err_reset: assert property (
        sys_error_in && s_reg.strap_done |=> hw_reset_req_out == $past(s_reg.cfg[SPC_CFG_HWRST])
        && sw_reset_req_out == !$past(s_reg.cfg[SPC_CFG_HWRST]))
        else $error("error reset path wrong");

    // ------------------------------------------------------------
    // Register access checks
    // ------------------------------------------------------------
    chk_vlan_write: assert property (
        wr_ok && reg_num_in == SPC_REG_VLAN && reg_idx_in <= SPC_PORT_MAX
        |=> s_reg.vlan[$past(reg_idx_in)] == $past(reg_wdata_in[3:0]))
        else $error("VLAN membership write lost");
    chk_vlan_void: assert property (
        reg_rd_in && !reg_wr_in && id_ok && s_reg.strap_done && reg_num_in == SPC_REG_VLAN
        && reg_idx_in > SPC_PORT_MAX |=> reg_rdata_out == 24'h000000)
        else $error("VLAN read beyond last port not zero");
    chk_dump_keep: assert property (
        wr_ok && reg_num_in == SPC_REG_DUMP && reg_wdata_in[4:0] > SPC_PORT_MAX
        |=> $stable(vlan_dump_port_out))
        else $error("invalid dump port ID accepted");
    chk_bp_read: assert property (
        reg_rd_in && id_ok && s_reg.strap_done && reg_num_in == SPC_REG_BP
        |=> reg_rdata_out == $past(s_reg.bp_mask))
        else $error("back-pressure mask read wrong");
    chk_lat_level: assert property (
        cfg_out.lat_level <= 4'h8)
        else $error("latch delay level out of range");
    chk_mem_size: assert property (
        $onehot(cfg_out.mem_words) && cfg_out.mem_words >= SPC_MEM_MIN)
        else $error("buffer memory size not a valid size");
    chk_phy_base: assert property (
        cfg_out.phy_id_base == (s_reg.cfg[SPC_CFG_PHYID] ? 5'h04 : 5'h01))
        else $error("PHY ID base wrong");
    chk_auto_track: assert property (
        auto_pm |=> link_status_out == $past(phy_link_in)
        && speed_status_out == $past(phy_speed_in)
        && duplex_mode_status_out == $past(phy_duplex_in))
        else $error("status not following PHY management");
    chk_manual_write: assert property (
        !auto_pm && wr_ok && reg_num_in == SPC_REG_DUPLEX_MODE_STATUS
        |=> duplex_mode_status_out == $past(reg_wdata_in[11:0]))
        else $error("duplex status write lost in manual mode");
    chk_pair_write: assert property (
        wr_ok && reg_num_in == SPC_REG_FDP
        |=> duplex_pair_enable_out == $past(reg_wdata_in[11:0]))
        else $error("duplex pairing write lost");
    chk_ack_idle: assert property (
        !((reg_wr_in || reg_rd_in) && id_ok && s_reg.strap_done) |=> !reg_ack_out)
        else $error("ack without accepted command");
    chk_err_idle: assert property (
        !sys_error_in |=> !sw_reset_req_out && !hw_reset_req_out)
        else $error("reset request without system error");

    cov_read: cover property (reg_rd_in && id_ok ##1 reg_ack_out);
    cov_id_miss: cover property (reg_wr_in && !id_ok && s_reg.strap_done);
    cov_manual_wr: cover property (!auto_pm && wr_ok && reg_num_in == SPC_REG_DUPLEX_MODE_STATUS);
    cov_hw_rst: cover property (hw_reset_req_out);
    cov_wait_run: cover property (s_reg.cfg[SPC_CFG_WAIT] && switch_run_out);

endmodule : spc_regs

// *** spc_pkg.sv ***
// Constants, field layout and state types of the switch port config registers.
// Assumes one 100 MHz clock and a register port driven by the UART command decoder.
package spc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int SPC_PORT_ISOLATE_MASK = 24;
    localparam int SPC_NVLAN = 4;
    localparam int SPC_NPAIR = 12;
    localparam int SPC_CFGW = 19;

    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [5:0] SPC_REG_SPEED = 6'h12;
    localparam logic [5:0] SPC_REG_LINK = 6'h13;
    localparam logic [5:0] SPC_REG_BP = 6'h15;
    localparam logic [5:0] SPC_REG_ISO = 6'h16;
    localparam logic [5:0] SPC_REG_VLAN = 6'h17;
    localparam logic [5:0] SPC_REG_DUMP = 6'h18;
    localparam logic [5:0] SPC_REG_CFG = 6'h19;
    localparam logic [5:0] SPC_REG_FDP = 6'h1A;
    localparam logic [5:0] SPC_REG_DUPLEX_MODE_STATUS = 6'h1B;

    // ------------------------------------------------------------
    // Configuration field positions
    // ------------------------------------------------------------
    localparam int SPC_CFG_LAT = 0;
    localparam int SPC_CFG_ORG = 4;
    localparam int SPC_CFG_SIZE = 5;
    localparam int SPC_CFG_LONG = 7;
    localparam int SPC_CFG_FLOOD = 8;
    localparam int SPC_CFG_EXTLU = 9;
    localparam int SPC_CFG_PHYID = 10;
    localparam int SPC_CFG_DROP = 11;
    localparam int SPC_CFG_NOPM = 12;
    localparam int SPC_CFG_RXFALL = 13;
    localparam int SPC_CFG_HWRST = 14;
    localparam int SPC_CFG_WAIT = 15;
    localparam int SPC_CFG_DEVID = 16;
    localparam int SPC_CFG_LUFALL = 18;

    // ------------------------------------------------------------
    // Reset values and decoded constants
    // ------------------------------------------------------------
    localparam logic [3:0] SPC_VLAN_RST = 4'h1;
    localparam logic [23:0] SPC_MASK_RST = 24'h000000;
    localparam logic [4:0] SPC_DUMP_RST = 5'h00;
    localparam logic [18:0] SPC_CFG_RST = 19'h00000;
    localparam logic [11:0] SPC_PAIR_RST = 12'h000;
    localparam logic [4:0] SPC_PORT_MAX = 5'h17;
    localparam logic [10:0] SPC_LONG_STD = 11'h5EE;
    localparam logic [10:0] SPC_LONG_EXT = 11'h5FA;
    localparam logic [4:0] SPC_PHYID_LO = 5'h01;
    localparam logic [4:0] SPC_PHYID_HI = 5'h04;
    localparam logic [19:0] SPC_MEM_MIN = 20'h10000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] bp_mask;
        logic [23:0] iso_mask;
        logic [23:0][3:0] vlan;
        logic [3:0][4:0] dump;
        logic [18:0] cfg;
        logic [11:0] pair;
        logic [11:0] duplex_mode_status;
        logic [23:0] speed;
        logic [23:0] link;
        logic strap_done;
        logic ack;
        logic [23:0] rdata;
        logic sw_rst;
        logic hw_rst;
    } spc_state_t;

    typedef struct packed {
        logic [3:0] lat_level;
        logic row_mode;
        logic [19:0] mem_words;
        logic [10:0] long_len;
        logic flood_unknown;
        logic ext_lookup;
        logic [4:0] phy_id_base;
        logic drop_excess_col;
        logic auto_phy_mgmt;
        logic rx_fall_edge;
        logic lookup_fall_edge;
    } spc_cfg_t;

endpackage : spc_pkg

// *** spc_cpu_model.sv ***
// Control CPU model for the switch port config registers: register port commands.
// Assumes the register port protocol of spc_regs: one-cycle strobes, ack one cycle later.
`timescale 1ns/1ps

module spc_cpu_model
    import spc_pkg::*;
(
    input wire logic clk_in, // 100 MHz clock
    input wire logic reg_ack_in, // Answer pulse
    input wire logic [23:0] reg_rdata_in, // Read data
    output logic reg_wr_out, // Write strobe
    output logic reg_rd_out, // Read strobe
    output logic [1:0] reg_dev_id_out, // Command device ID
    output logic [5:0] reg_num_out, // Register number
    output logic [4:0] reg_idx_out, // Port or VLAN index
    output logic [23:0] reg_wdata_out, // Write data
    output logic sys_ready_out // System-ready bit
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_dev_id_out = 2'h0;
        reg_num_out = 6'h00;
        reg_idx_out = 5'h00;
        reg_wdata_out = 24'h000000;
        sys_ready_out = 1'b0;
    end

    // One command; after the strobe, number, index and data lines show inverted values, not the last ones
    task automatic xfer(input logic wr, input logic rd, input logic [1:0] id,
        input logic [5:0] num, input logic [4:0] idx, input logic [23:0] wd,
        output logic [23:0] rdat, output logic got);
        int n;
        @(posedge clk_in);
        reg_wr_out <= wr;
        reg_rd_out <= rd;
        reg_dev_id_out <= id;
        reg_num_out <= num;
        reg_idx_out <= idx;
        reg_wdata_out <= wd;
        @(posedge clk_in);
        reg_wr_out <= 1'b0;
        reg_rd_out <= 1'b0;
        reg_wdata_out <= ~wd;
        reg_num_out <= ~num;
        reg_idx_out <= ~idx;
        got = 1'b0;
        rdat = 24'h000000;
        for (n = 0; n < 3; n++) begin
            #1;
            if (reg_ack_in === 1'b1) begin
                got = 1'b1;
                rdat = reg_rdata_in;
                break;
            end
            @(posedge clk_in);
        end
    endtask : xfer

    task automatic set_ready(input logic v);
        @(posedge clk_in);
        sys_ready_out <= v;
    endtask : set_ready
endmodule : spc_cpu_model

// *** tb_spc_regs.sv ***
// Self-checking bench for spc_regs: strap load, register access, decode, status, errors.
// Assumes spc_cpu_model drives the register port and holds the system-ready bit.
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, (a), (b)); end end

module tb_spc_regs;
    import spc_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, sys_error_in = 1'b0;
    logic wr, rd, ack, ready, run, swr, hwr, got;
    logic [1:0] id, dev;
    logic [5:0] num;
    logic [4:0] idx;
    logic [23:0] wd, rdat, bpe, pte, spd_o, lnk_o;
    logic [23:0] phy_speed = 24'h000000, phy_link = 24'h000000;
    logic [11:0] phy_duplex_mode_status = 12'h000, pair_o, duplex_mode_status_o;
    logic [18:0] strap = 19'h1A6D3;
    logic [11:0] pair_strap = 12'hA5C;
    logic [95:0] vlan_o;
    logic [19:0] dump_o;
    logic [18:0] v;
    spc_cfg_t cfg_o;
    int error_cnt = 0, n_tests = 0, i;
    logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD, 4'hF};

    always #5 clk_in = ~clk_in;

    spc_cpu_model spc_cpu_model_i (.clk_in(clk_in), .reg_ack_in(ack), .reg_rdata_in(rdat),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_dev_id_out(id), .reg_num_out(num),
        .reg_idx_out(idx), .reg_wdata_out(wd), .sys_ready_out(ready));

    spc_regs spc_regs_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_dev_id_in(id), .reg_num_in(num), .reg_idx_in(idx), .reg_wdata_in(wd),
        .reg_ack_out(ack), .reg_rdata_out(rdat), .strap_cfg_in(strap),
        .duplex_pair_strap_value_in(pair_strap), .phy_speed_in(phy_speed),
        .phy_link_in(phy_link), .phy_duplex_in(phy_duplex_mode_status), .sys_ready_in(ready),
        .sys_error_in(sys_error_in), .bp_enable_out(bpe), .port_enable_out(pte),
        .vlan_member_out(vlan_o), .vlan_dump_port_out(dump_o), .cfg_out(cfg_o),
        .duplex_pair_enable_out(pair_o), .duplex_mode_status_out(duplex_mode_status_o),
        .speed_status_out(spd_o), .link_status_out(lnk_o), .switch_run_out(run),
        .sw_reset_req_out(swr), .hw_reset_req_out(hwr));

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic wreg(input logic [5:0] n, input logic [4:0] x, input logic [23:0] d);
        logic [23:0] r;
        logic g;
        spc_cpu_model_i.xfer(1'b1, 1'b0, dev, n, x, d, r, g);
        `CHK(g, 1'b1)
    endtask : wreg

    task automatic rreg(input logic [5:0] n, input logic [4:0] x, output logic [23:0] r);
        logic g;
        spc_cpu_model_i.xfer(1'b0, 1'b1, dev, n, x, 24'h000000, r, g);
        `CHK(g, 1'b1)
    endtask : rreg

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : settle

    initial begin
        #100us;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        logic [23:0] r;
        dev = 2'h1;
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        settle(2);
        `CHK(run, 1'b0)
        rreg(SPC_REG_CFG, 5'h00, r); `CHK(r, 24'h01A6D3)
        rreg(SPC_REG_FDP, 5'h00, r); `CHK(r, 24'h000A5C)
        `CHK(cfg_o.auto_phy_mgmt, 1'b1)
        spc_cpu_model_i.set_ready(1'b1);
        settle(1); `CHK(run, 1'b1)
        spc_cpu_model_i.xfer(1'b0, 1'b1, 2'h0, SPC_REG_CFG, 5'h00, 24'h0, r, got);
        `CHK(got, 1'b0)
        for (i = 0; i < 24; i++) begin
            rreg(SPC_REG_VLAN, i[4:0], r); `CHK(r, 24'h000001)
        end
        wreg(SPC_REG_VLAN, 5'h05, 24'h00000B); `CHK(vlan_o[23:20], 4'hB)
        wreg(SPC_REG_VLAN, 5'h17, 24'h00000F); `CHK(vlan_o[95:92], 4'hF)
        rreg(SPC_REG_VLAN, 5'h05, r); `CHK(r, 24'h00000B)
        rreg(SPC_REG_VLAN, 5'h18, r); `CHK(r, 24'h000000)
        wreg(SPC_REG_BP, 5'h00, 24'h800001); `CHK(bpe, 24'h7FFFFE)
        rreg(SPC_REG_BP, 5'h00, r); `CHK(r, 24'h800001)
        wreg(SPC_REG_ISO, 5'h00, 24'h400010); `CHK(pte, 24'hBFFFEF)
        wreg(SPC_REG_DUMP, 5'h03, 24'h000017); `CHK(dump_o[19:15], 5'h17)
        wreg(SPC_REG_DUMP, 5'h03, 24'h000018); `CHK(dump_o[19:15], 5'h17)
        rreg(SPC_REG_DUMP, 5'h03, r); `CHK(r, 24'h000017)
        rreg(SPC_REG_DUMP, 5'h04, r); `CHK(r, 24'h000000)
        wreg(SPC_REG_FDP, 5'h00, 24'h000123); `CHK(pair_o, 12'h123)
        rreg(6'h3E, 5'h00, r); `CHK(r, 24'h000000)
        for (i = 0; i < 9; i++) begin
            v = 19'h10000 | {15'h0, codes[i]} | (19'(i % 4) << 5) | (i[0] ? 19'h46F90 : 19'h0);
            wreg(SPC_REG_CFG, 5'h00, {5'h00, v});
            `CHK(cfg_o.lat_level, i[3:0])
            `CHK(cfg_o.row_mode, i[0])
            `CHK(cfg_o.mem_words, 20'h10000 << (i % 4))
            `CHK(cfg_o.long_len, i[0] ? 11'h5FA : 11'h5EE)
            `CHK(cfg_o.flood_unknown, i[0])
            `CHK(cfg_o.ext_lookup, i[0])
            `CHK(cfg_o.phy_id_base, i[0] ? 5'h04 : 5'h01)
            `CHK(cfg_o.drop_excess_col, i[0])
            `CHK(cfg_o.rx_fall_edge, i[0])
            `CHK(cfg_o.lookup_fall_edge, i[0])
            @(posedge clk_in); sys_error_in <= 1'b1;
            @(posedge clk_in); sys_error_in <= 1'b0;
            #1; `CHK({hwr, swr}, {i[0], ~i[0]})
        end
        @(posedge clk_in);
        phy_link <= 24'hA50F0C; phy_speed <= 24'h00FF00; phy_duplex_mode_status <= 12'h5A5;
        settle(2);
        `CHK(lnk_o, 24'hA50F0C)
        `CHK(duplex_mode_status_o, 12'h5A5)
        wreg(SPC_REG_LINK, 5'h00, 24'h111111); `CHK(lnk_o, 24'hA50F0C)
        wreg(SPC_REG_DUPLEX_MODE_STATUS, 5'h00, 24'h000FFF); `CHK(duplex_mode_status_o, 12'h5A5)
        rreg(SPC_REG_SPEED, 5'h00, r); `CHK(r, 24'h00FF00)
        wreg(SPC_REG_CFG, 5'h00, 24'h011000); `CHK(cfg_o.auto_phy_mgmt, 1'b0)
        @(posedge clk_in);
        phy_link <= 24'h000000;
        settle(2); `CHK(lnk_o, 24'hA50F0C)
        wreg(SPC_REG_LINK, 5'h00, 24'h3C3C3C); `CHK(lnk_o, 24'h3C3C3C)
        wreg(SPC_REG_SPEED, 5'h00, 24'h0000F0); `CHK(spd_o, 24'h0000F0)
        wreg(SPC_REG_DUPLEX_MODE_STATUS, 5'h00, 24'h0003C3); `CHK(duplex_mode_status_o, 12'h3C3)
        wreg(SPC_REG_CFG, 5'h00, 24'h029000); `CHK(run, 1'b1)
        spc_cpu_model_i.set_ready(1'b0);
        settle(1); `CHK(run, 1'b0)
        spc_cpu_model_i.xfer(1'b0, 1'b1, 2'h1, SPC_REG_CFG, 5'h00, 24'h0, r, got);
        `CHK(got, 1'b0)
        dev = 2'h2;
        rreg(SPC_REG_CFG, 5'h00, r); `CHK(r, 24'h029000)
        spc_cpu_model_i.xfer(1'b1, 1'b0, 2'h1, SPC_REG_BP, 5'h00, 24'h00FFFF, r, got);
        `CHK(got, 1'b0)
        `CHK(bpe, 24'h7FFFFE)
        report_and_stop();
    end
endmodule : tb_spc_regs
